/* rtl/io_xchg_defines.svh */
// Purpose: constants for the I/O register exchange decoder and the backplane bus.
// Assumes: 16-bit words, octal address ranges given as sized hex values.
// Notes:   included by both ends and the test bench.
// Summary of operation
// - direct exchange address from instruction bits 10..0
// - software loads T before indirect exchange
// - indirect exchange uses all sixteen T bits
// - address bit 0: zero input, one output
// - exchange only moves one word, nothing else
// - direct exchange reaches all 2048 registers
// - direct bit 10 selects maker or customer
// - maker registers lie within octal 0-1777
// - indirect with bits 15..11 zero matches direct
// - bit15 zero, bits 14..11 nonzero is illegal
// - bit 15 set reaches indirect-only registers
// - octal 100000-100777 are system control registers
// - error correction transfer becomes indirect 100115
// - octal 101000-107777 reserved, no function
// - octal 110000-177777 reserved, no function
// - under operating system, nonprivileged use flagged
// - OS off, paging off: exchange unprivileged
// - controllers never start transfers themselves
// - data only with programmed-transfer data registers
// - written registers odd, read registers even
// - one module serves at most four devices
`ifndef IO_XCHG_DEFINES_SVH
`define IO_XCHG_DEFINES_SVH
`define DIRECT_ADDR_BITS      11
`define CUSTOMER_BIT          10
`define MAKER_LIMIT           16'h03ff
`define SYSCTL_LO             16'h8000
`define SYSCTL_HI             16'h81ff
`define MAKER_RSV_LO          16'h8200
`define MAKER_RSV_HI          16'h8fff
`define EXT_RSV_LO            16'h9000
`define ECC_CTRL_ADDR         16'h804d
`define EXEC_TIMEOUT          16'h00ff
// register offsets of the cpu decoder (apb byte addresses)
`define REG_CMD               12'h000
`define REG_INSTR             12'h004
`define REG_TREG              12'h008
`define REG_AREG              12'h00c
`define REG_STATUS            12'h010
`define REG_MODE              12'h014
// command register fields
`define CMD_GO_BIT            0
`define CMD_INDIRECT_BIT      1
`define CMD_ECC_XFER_BIT      2
// mode register fields
`define MODE_OS_BIT           0
`define MODE_PAGING_BIT       1
`define MODE_PRIV_BIT         2
`endif

/* rtl/io_xchg_pkg.sv */
// Purpose: types shared by the decoder ends.
// Assumes: nothing beyond the defines header.
// Notes:   address classes of the register space.
package io_xchg_pkg;
   typedef enum logic [2:0] {
      CLS_MAKER, CLS_CUSTOMER, CLS_ILLEGAL, CLS_SYSCTL, CLS_MAKER_RSV, CLS_EXT_RSV
   } addr_class_e;
   typedef logic [15:0] word_t;
endpackage

/* rtl/io_xchg_if.sv */
// Purpose: backplane register exchange link between cpu decoder and controllers.
// Assumes: single clock; request held until ack.
// Notes:   dir high is output from the a register.
`timescale 1ns/10ps
interface io_xchg_if (
   input wire logic i_clk     // shared clock
);
   logic        req;
   logic        dir_out;
   logic [15:0] addr;
   logic [15:0] wdata;
   logic        ack;
   logic [15:0] rdata;
   modport cpu  (output req, output dir_out, output addr, output wdata,
                 input ack, input rdata);
   modport ctrl (input req, input dir_out, input addr, input wdata,
                 output ack, output rdata);
endinterface

/* rtl/io_xchg_ctrl.sv */
// Purpose: device controller end holding four programmed-transfer registers.
// Assumes: cpu holds req until ack; one clock.
// Notes:   odd addresses written, even ones read.
`timescale 1ns/10ps
`include "io_xchg_defines.svh"
module io_xchg_ctrl
   import io_xchg_pkg::*;
#(
   parameter logic [15:0] BASE_ADDR = 16'h00c0
) (
   input  wire logic        i_clk,       // system clock
   input  wire logic        i_arst_n,    // async reset, active low
   io_xchg_if.ctrl          link,        // backplane side
   input  wire logic [15:0] i_status,    // device status to read
   input  wire logic [15:0] i_rx_data,   // device input data
   output logic      [15:0] o_ctrl,      // last control word
   output logic      [15:0] o_tx_data,   // last output data
   output logic             o_tx_stb     // pulse on output data write
);
   // module occupies base+0..3: 0 rx data, 1 tx data, 2 status, 3 control
   logic hit;
   assign hit = link.req && (link.addr[15:2] == BASE_ADDR[15:2]);

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         link.ack   <= 1'b0;
         link.rdata <= 16'h0000;
      end else begin
         link.ack <= hit && !link.ack;
         if (hit && !link.dir_out) begin
            link.rdata <= link.addr[1] ? i_status : i_rx_data;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_ctrl    <= 16'h0000;
         o_tx_data <= 16'h0000;
         o_tx_stb  <= 1'b0;
      end else begin
         o_tx_stb <= 1'b0;
         // writes only on command from the cpu, never self-started
         if (hit && !link.ack && link.dir_out) begin
            if (link.addr[1]) begin
               o_ctrl <= link.wdata;
            end else begin
               o_tx_data <= link.wdata;
               o_tx_stb  <= 1'b1;
            end
         end
      end
   end
endmodule

/* rtl/io_xchg_cpu.sv */
// Purpose: cpu-side decoder executing direct and indirect register exchanges.
// Assumes: apb master software issues orders; backplane device acks in time.
// Notes:   unclaimed addresses end with a timeout flag instead of a hang.
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`include "io_xchg_defines.svh"
module io_xchg_cpu
   import io_xchg_pkg::*;
(
   input  wire logic        i_clk,       // system clock
   input  wire logic        i_arst_n,    // async reset, active low
   input  wire logic        i_psel,      // apb select
   input  wire logic        i_penable,   // apb enable
   input  wire logic        i_pwrite,    // apb direction
   input  wire logic [11:0] i_paddr,     // apb byte address
   input  wire logic [31:0] i_pwdata,    // apb write data
   output logic      [31:0] o_prdata,    // apb read data
   output logic             o_pready,    // apb ready
   output logic             o_pslverr,   // apb error
   io_xchg_if.cpu           link         // backplane side
);
   typedef enum {ST_IDLE, ST_WAIT, ST_DONE} xchg_state_e;

   logic [15:0] instr_word;
   logic [15:0] t_reg;
   logic [15:0] a_reg;
   logic [2:0]  mode;
   logic        busy;
   logic        illegal_err;
   logic        priv_err;
   logic        timeout_err;
   logic        done;
   logic [2:0]  cls_last;
   logic [15:0] wait_cnt;
   xchg_state_e state;

   function automatic addr_class_e classify(input logic [15:0] a);
      // bit 15 first: the indirect-only space needs no further legality check
      if (a[15]) begin
         if (a <= `SYSCTL_HI) classify = CLS_SYSCTL;
         else if (a <= `MAKER_RSV_HI) classify = CLS_MAKER_RSV;
         else classify = CLS_EXT_RSV;
      end else if (a[14:11] != 4'h0) begin
         classify = CLS_ILLEGAL;
      end else if (a[`CUSTOMER_BIT]) begin
         classify = CLS_CUSTOMER;
      end else begin
         classify = CLS_MAKER;
      end
   endfunction

   // status layout: class 8:6, timeout 5, privilege 4, illegal 3, done 1, busy 0
   function automatic logic [31:0] status_word(input logic [2:0] cls, input logic tmo,
                                               input logic prv, input logic ill,
                                               input logic dn, input logic bsy);
      status_word = {23'h00_0000, cls, tmo, prv, ill, 1'b0, dn, bsy};
   endfunction

   // apb access completes in its access cycle; unmapped gives pslverr
   logic        apb_acc;
   logic        apb_wr;
   logic        mapped;
   logic [15:0] cmd_wd;
   assign apb_acc = i_psel && i_penable;
   assign apb_wr  = apb_acc && i_pwrite;
   assign mapped  = (i_paddr <= `REG_MODE) && (i_paddr[1:0] == 2'b00);
   assign cmd_wd  = i_pwdata[15:0];

   // next exchange address: direct from instruction, indirect from t
   logic [15:0] next_addr;
   addr_class_e next_cls;
   logic        go;
   logic        privileged_ok;
   always_comb begin
      if (cmd_wd[`CMD_ECC_XFER_BIT]) begin
         next_addr = `ECC_CTRL_ADDR;
      end else if (cmd_wd[`CMD_INDIRECT_BIT]) begin
         next_addr = t_reg;
      end else begin
         next_addr = {5'b00000, instr_word[`DIRECT_ADDR_BITS-1:0]};
      end
   end
   // classes are decoded once here; reserved ranges still go out and time out
   assign next_cls = classify(next_addr);
   // a go while busy is dropped, not queued: one exchange at a time
   assign go = apb_wr && (i_paddr == `REG_CMD) && cmd_wd[`CMD_GO_BIT] && !busy;
   // os running needs the privilege bit; os off and paging off runs freely
   assign privileged_ok = !mode[`MODE_OS_BIT] ? !mode[`MODE_PAGING_BIT] || mode[`MODE_PRIV_BIT]
                                              : mode[`MODE_PRIV_BIT];

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata  <= 32'h0000_0000;
      end else begin
         // zero wait states: ready stands in the first access cycle, read data latched in setup
         o_pready  <= i_psel && !i_penable;
         o_pslverr <= i_psel && !i_penable && !mapped;
         o_prdata  <= 32'h0000_0000;
         if (i_psel && !i_penable && !i_pwrite) begin
            case (i_paddr)
               `REG_INSTR:  o_prdata <= {16'h0000, instr_word};
               `REG_TREG:   o_prdata <= {16'h0000, t_reg};
               `REG_AREG:   o_prdata <= {16'h0000, a_reg};
               `REG_STATUS: o_prdata <= status_word(cls_last, timeout_err, priv_err,
                                                    illegal_err, done, busy);
               `REG_MODE:   o_prdata <= {29'h0000_0000, mode};
               default:     o_prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // software-owned registers; a is also loaded by input exchanges
   // writes land at the access edge, the same edge the master samples ready on
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         instr_word <= 16'h0000;
         t_reg      <= 16'h0000;
         mode       <= 3'b000;
      end else if (apb_wr && o_pready && mapped) begin
         case (i_paddr)
            `REG_INSTR: instr_word <= i_pwdata[15:0];
            `REG_TREG:  t_reg      <= i_pwdata[15:0];
            `REG_MODE:  mode       <= i_pwdata[2:0];
            default:    ;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state       <= ST_IDLE;
         busy        <= 1'b0;
         done        <= 1'b0;
         illegal_err <= 1'b0;
         priv_err    <= 1'b0;
         timeout_err <= 1'b0;
         cls_last    <= 3'b000;
         wait_cnt    <= 16'h0000;
         link.req     <= 1'b0;
         link.dir_out <= 1'b0;
         link.addr    <= 16'h0000;
         link.wdata   <= 16'h0000;
      end else begin
         case (state)
            ST_IDLE: begin
               if (go && o_pready) begin
                  cls_last    <= next_cls;
                  done        <= 1'b0;
                  illegal_err <= 1'b0;
                  priv_err    <= 1'b0;
                  timeout_err <= 1'b0;
                  if (!privileged_ok) begin
                     priv_err <= 1'b1;
                     done     <= 1'b1;
                  end else if (next_cls == CLS_ILLEGAL) begin
                     // reported through status only; the backplane stays quiet
                     illegal_err <= 1'b1;   // no bus access
                     done        <= 1'b1;
                  end else begin
                     // one word moves between a and the register, nothing more
                     link.req     <= 1'b1;
                     link.addr    <= next_addr;
                     link.dir_out <= next_addr[0];
                     link.wdata   <= a_reg;
                     busy         <= 1'b1;
                     wait_cnt     <= 16'h0000;
                     state        <= ST_WAIT;
                  end
               end
            end
            ST_WAIT: begin
               wait_cnt <= wait_cnt + 16'h0001;
               if (link.ack) begin
                  link.req <= 1'b0;
                  state    <= ST_DONE;
               // the bound keeps an empty or reserved address from hanging the cpu
               end else if (wait_cnt == `EXEC_TIMEOUT) begin
                  // reserved or empty addresses answer nobody
                  timeout_err <= 1'b1;
                  link.req    <= 1'b0;
                  state       <= ST_DONE;
               end
            end
            ST_DONE: begin
               // done rises after the link has dropped, so software never sees both
               busy  <= 1'b0;
               done  <= 1'b1;
               state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // a takes the answer at the ack edge, where rdata is valid;
   // software may load it only while no exchange is running
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         a_reg <= 16'h0000;
      end else if (state == ST_WAIT && link.ack && !link.dir_out) begin
         a_reg <= link.rdata;
      end else if (apb_wr && o_pready && i_paddr == `REG_AREG && !busy) begin
         a_reg <= i_pwdata[15:0];
      end
   end
endmodule

/* bench/io_xchg_link_sva.sv */
// Purpose: link checks between the cpu decoder and the controller.
// Assumes: one clock, async active-low reset.
// Notes:   a counter bounds how long a request may wait unanswered.
`timescale 1ns/10ps
module io_xchg_link_sva #(
   parameter logic [15:0] BASE_ADDR = 16'h00c0
) (
   input wire logic        i_clk,    // clock
   input wire logic        i_arst_n, // reset, active low
   input wire logic        req,      // exchange request
   input wire logic        dir_out,  // output direction
   input wire logic [15:0] addr,     // register address
   input wire logic [15:0] wdata,    // output word
   input wire logic        ack       // controller answer
);
   logic [9:0] wait_cnt;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n)
         wait_cnt <= '0;
      else if (req && !ack)
         wait_cnt <= wait_cnt + 10'd1;
      else
         wait_cnt <= '0;
   end
   chk_dir_from_bit0: assert property (req |-> dir_out == addr[0])
      else $error("direction differs from address bit 0");
   chk_no_illegal_req: assert property (req |-> !(!addr[15] && addr[14:11] != 4'h0))
      else $error("illegal address reached the link");
   chk_req_held: assert property (req && !ack |=>
      !req || ($stable(addr) && $stable(dir_out) && $stable(wdata)))
      else $error("request changed before answer");
   chk_ack_on_match: assert property ($rose(req) && addr[15:2] == BASE_ADDR[15:2] |=> ack)
      else $error("controller missed its address");
   chk_ack_needs_req: assert property (ack |-> req && $past(req))
      else $error("answer without request");
   chk_one_word: assert property (ack |=> !ack && !req)
      else $error("more than one word per exchange");
   chk_no_stray_ack: assert property ($rose(req) && addr[15:2] != BASE_ADDR[15:2] |=>
      (!ack) [*4])
      else $error("foreign address answered");
   chk_wait_bounded: assert property (wait_cnt <= 10'd270)
      else $error("unanswered request never released");
endmodule

/* bench/io_register_address_decoder_test.sv */
// Purpose: drives the cpu decoder over apb against one controller.
// Assumes: controller at 16'h00c0, no other responder on the link.
// Notes:   customer and reserved ranges end in the cpu timeout.
`timescale 1ns/10ps
`include "io_xchg_defines.svh"
module io_register_address_decoder_test;
   logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, tx_stb, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, st;
   logic [15:0] status_in, rx_in, ctrl_out, tx_out, last_addr;
   int          n_mismatch, checks, cyc, n_stb;
   logic [2:0]  t_cmd  [15] = '{3'h1, 3'h3, 3'h1, 3'h3, 3'h1, 3'h3, 3'h3, 3'h3,
                                3'h5, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3};
   logic [15:0] t_addr [15] = '{16'hf8c1, 16'h00c3, 16'h00c0, 16'h00c2, 16'h04c1,
                                16'h0800, 16'h7801, 16'h8000, 16'h0000, 16'h81ff,
                                16'h8200, 16'h8fff, 16'h9000, 16'hffff, 16'h07ff};
   logic [8:0]  t_exp  [15] = '{9'h002, 9'h002, 9'h002, 9'h002, 9'h062, 9'h08a, 9'h08a,
                                9'h0e2, 9'h0e2, 9'h0e2, 9'h122, 9'h122, 9'h162, 9'h162, 9'h062};
   logic [2:0]  p_mode [4]  = '{3'h1, 3'h5, 3'h2, 3'h0};
   logic [8:0]  p_exp  [4]  = '{9'h012, 9'h002, 9'h012, 9'h002};
   io_xchg_if i_io_xchg_if (.i_clk(clk));
   io_xchg_cpu i_io_xchg_cpu (.i_clk(clk), .i_arst_n(arst_n), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .link(i_io_xchg_if));
   io_xchg_ctrl #(.BASE_ADDR(16'h00c0)) i_io_xchg_ctrl (.i_clk(clk), .i_arst_n(arst_n),
      .link(i_io_xchg_if), .i_status(status_in), .i_rx_data(rx_in), .o_ctrl(ctrl_out),
      .o_tx_data(tx_out), .o_tx_stb(tx_stb));
   io_xchg_link_sva #(.BASE_ADDR(16'h00c0)) i_io_xchg_link_sva (.i_clk(clk),
      .i_arst_n(arst_n), .req(i_io_xchg_if.req), .dir_out(i_io_xchg_if.dir_out),
      .addr(i_io_xchg_if.addr), .wdata(i_io_xchg_if.wdata), .ack(i_io_xchg_if.ack));
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic err);
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // ready is read as it stood at the edge; if ready never comes, only the bench timeout ends this wait
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r   = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic xchg(input logic [2:0] cmd, input logic [15:0] a, output logic [31:0] s);
      apb(1'b1, `REG_AREG, 32'h0000_1234, rd, e);
      apb(1'b1, cmd[1] ? `REG_TREG : `REG_INSTR, {16'h0000, a}, rd, e);
      apb(1'b1, `REG_CMD, {29'h0, cmd}, rd, e);
      s = 32'h0000_0000;
      while (s[1] !== 1'b1) begin
         apb(1'b0, `REG_STATUS, 32'h0000_0000, s, e);
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (i_io_xchg_if.req === 1'b1)
         last_addr <= i_io_xchg_if.addr;
      if (tx_stb === 1'b1)
         n_stb <= n_stb + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         end_sim();
      end
   end
   initial begin
      arst_n    = 1'b0;
      psel      = 1'b0;
      penable   = 1'b0;
      pwrite    = 1'b0;
      paddr     = 12'h000;
      pwdata    = 32'h0000_0000;
      status_in = 16'h5aa5;
      rx_in     = 16'hc3e1;
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      for (int i = 0; i < 15; i++) begin
         xchg(t_cmd[i], t_addr[i], st);
         cmp(st[8:0] & 9'h1fb, t_exp[i], "class");
         apb(1'b0, `REG_AREG, 32'h0000_0000, rd, e);
         if (i == 0) cmp(tx_out, 16'h1234, "tx data");
         if (i == 1) cmp(ctrl_out, 16'h1234, "ctrl word");
         if (i == 2) cmp(rd, {16'h0000, rx_in}, "rx data");
         if (i == 3) cmp(rd, {16'h0000, status_in}, "status word");
         if (i == 8) cmp(last_addr, 16'h804d, "ecc address");
      end
      $display("test address classes ended");
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, `REG_MODE, {29'h0, p_mode[i]}, rd, e);
         xchg(3'h1, 16'h00c1, st);
         cmp(st[8:0] & 9'h013, p_exp[i], "privilege");
      end
      cmp(n_stb, 32'h0000_0003, "tx strobes");
      $display("test privilege ended");
      apb(1'b0, 12'h018, 32'h0000_0000, rd, e);
      cmp(e, 1'b1, "unmapped offset");
      $display("test register map ended");
      end_sim();
   end
endmodule
